// file: tsc_map.svh
// Command codes, field positions, reset values and counts of the touch
// state and setup logic. Definitions only; included by the design files.
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// Command bytes from the serial engine
`define TSC_OP_SOFT_RESET 8'h00
`define TSC_OP_CLEAR_ALERT 8'h03
`define TSC_OP_WR_SETUP 8'h30
`define TSC_OP_RD_SETUP 8'h33
`define TSC_OP_WR_TUNING 8'h35
`define TSC_OP_RD_TUNING 8'h36
`define TSC_OP_WR_CHAN_EN 8'h39
`define TSC_OP_RD_CHAN_EN 8'h3A
`define TSC_OP_BUS_ALERT 8'h3C

// Field positions of the setup byte
`define TSC_OPM_HI 7
`define TSC_OPM_LO 6
`define TSC_SWITCH_BIT 5
`define TSC_KEY_HI 4
`define TSC_KEY_LO 3
`define TSC_REG_OFF_BIT 2
`define TSC_EDGE_BIT 1
`define TSC_PWR_BIT 0

// Unused bit of the clock tuning byte
`define TSC_TUNING_SPARE_BIT 5

// Reset values
`define TSC_SETUP_RESET 8'h00
`define TSC_STATE_RESET 8'h00
`define TSC_TUNING_RESET 8'h0C
`define TSC_CHAN_EN_RESET 8'hFF

// Accepted-key limits per key-press mode
`define TSC_LIMIT_N 4'h8
`define TSC_LIMIT_TWO 4'h2
`define TSC_LIMIT_ONE 4'h1

// Sample divider on clk_in, link divider on the cascade clock
`define TSC_SAMPLE_DIV 8
`define TSC_LINK_DIV 8

`endif

// file: tsc_pkg.sv
// Types of the touch state and setup logic.
// Assumes tsc_map.svh carries the matching numbers.
package tsc_pkg;

   typedef enum logic [1:0] {
      TSC_OPM_ALONE = 2'h0,
      TSC_OPM_SECONDARY = 2'h1,
      TSC_OPM_PRIMARY = 2'h2,
      TSC_OPM_UNUSED = 2'h3
   } tsc_opmode_t;

   typedef enum logic [1:0] {
      TSC_KEY_N = 2'h0,
      TSC_KEY_TWO = 2'h1,
      TSC_KEY_ONE = 2'h2,
      TSC_KEY_UNUSED = 2'h3
   } tsc_keymode_t;

   // Setup byte, bit 7 first
   typedef struct packed {
      tsc_opmode_t operating_mode_select;
      logic switch_behaviour_select;
      tsc_keymode_t key_press_select;
      logic regulator_off;
      logic alert_edge_select;
      logic masked_channel_power;
   } tsc_setup_t;

   // Clock tuning byte, bit 7 first
   typedef struct packed {
      logic clock_output_switch;
      logic clock_input_switch;
      logic spare;
      logic [1:0] coarse_divider;
      logic [2:0] oscillator_trim;
   } tsc_tuning_t;

   // One command from the serial engine
   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [7:0] data;
   } tsc_cmd_t;

   // Clock routing controls
   typedef struct packed {
      logic osc_enable;
      logic clk_out_enable;
      logic clk_in_enable;
   } tsc_route_t;

endpackage

// file: tsc_sync.sv
// Two-flop synchroniser bank.
// Assumes d_in is stable per bit; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none

module tsc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;

endmodule

`default_nettype wire

// file: tsc_core.sv
// Touch state, setup registers and clock routing of the eight-channel
// touch sensor. Assumes commands arrive already decoded from the serial
// engine on clk_in; sense pins and the cascade clock are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"

// What this block does
// - Setup bits 7:6 pick stand-alone 00, cascade secondary 01, primary 10.
// - After reset runs stand-alone on internal oscillator, cascade pins off.
// - Cascade primary: clock driven out; oscillator on, clock input off unless tuning bit 6 set.
// - Cascade secondary: oscillator off, clock from input, clock output per tuning bit 7.
// - Each of the eight sense channels owns one touch state bit.
// - Setup bit 5 picks direct 0 or latching 1; direct after reset.
// - Direct mode: bit follows press and release, read or not.
// - Latching: press sets, release keeps; read clears released bits.
// - Setup bits 4:3 pick N-key 00, 2-key 01, 1-key 10.
// - N-key after reset; every enabled channel reaches the state register.
// - 1-key mode: only the first activation sets its bit.
// - 1-key mode: each accepted activation alerts, blocked ones do not; controller copes with early alert.
// - 2-key mode: only the first two activations set their bits.
// - 2-key mode: alert only once two bits are set.
// - Setup bit 1, ignored in 2-key mode: 0 alerts on any change, 1 on presses only.
// - Setup bit 0: 1 powers down disabled channels, 0 keeps them.
// - Setup byte is written and read by its own commands.
// - Soft reset restores all registers, channels, ends bus alert mode.
// - State read or clear-alert command drops the alert line unless a new event fires in the same cycle.
module tsc_core
   import tsc_pkg::*;
#(
   parameter int SAMPLE_DIV = `TSC_SAMPLE_DIV,
   parameter int LINK_DIV = `TSC_LINK_DIV
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic cascade_clk_in,
   input wire logic [7:0] sense_in,
   input wire tsc_cmd_t cmd_in,
   input wire logic state_read_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic alert_n_out,
   output logic bus_alert_mode_out,
   output logic cascade_clk_out,
   output var tsc_route_t route_out,
   output logic [7:0] channel_power_down_out,
   output logic regulator_off_out
);

   // Ones in a channel vector
   function automatic logic [3:0] tsc_count(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   // Accepted-key limit of a key-press code; unused code acts as N-key
   function automatic logic [3:0] tsc_limit(input tsc_keymode_t km);
      case (km)
         TSC_KEY_TWO: return `TSC_LIMIT_TWO;
         TSC_KEY_ONE: return `TSC_LIMIT_ONE;
         default: return `TSC_LIMIT_N;
      endcase
   endfunction

   tsc_setup_t setup_q, setup_d;
   tsc_tuning_t tuning_q, tuning_d;
   logic [7:0] chan_en_q, chan_en_d;
   logic bus_alert_q, bus_alert_d;
   logic [7:0] state_q, state_d;
   logic alert_q, alert_d;
   logic fire;
   tsc_route_t route_q, route_d;
   logic [7:0] pwr_q, pwr_d;
   logic casc_q, casc_d;
   logic [7:0] div_q, div_d;
   logic [7:0] rd_data_q, rd_data_d;
   logic rd_valid_q, rd_valid_d;
   logic tgl_prev_q;
   logic [7:0] sense_s;
   logic [7:0] active;
   logic tgl_s;
   logic link_edge;
   logic int_tick;
   logic tick;
   logic soft_rst;
   logic clear_cmd;
   logic [3:0] key_limit;
   logic link_en;
   logic [7:0] link_cnt_q, link_cnt_d;
   logic link_tgl_q, link_tgl_d;

   // Command decode
   assign soft_rst = cmd_in.valid && (cmd_in.code == `TSC_OP_SOFT_RESET);
   assign clear_cmd = cmd_in.valid && (cmd_in.code == `TSC_OP_CLEAR_ALERT);
   assign key_limit = tsc_limit(setup_q.key_press_select);

   // Sense pins into the clk_in domain
   tsc_sync #(.WIDTH(8)) u_sense_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .d_in(sense_in),
      .q_out(sense_s)
   );

   // Disabled channels never count as pressed
   assign active = sense_s & chan_en_q;

   // Register writes, soft reset back to defaults
   always_comb begin
      setup_d = setup_q;
      tuning_d = tuning_q;
      chan_en_d = chan_en_q;
      bus_alert_d = bus_alert_q;
      if (soft_rst) begin
         setup_d = tsc_setup_t'(`TSC_SETUP_RESET);
         tuning_d = tsc_tuning_t'(`TSC_TUNING_RESET);
         chan_en_d = `TSC_CHAN_EN_RESET;
         bus_alert_d = 1'b0;
      end else if (cmd_in.valid) begin
         case (cmd_in.code)
            `TSC_OP_WR_SETUP: setup_d = tsc_setup_t'(cmd_in.data);
            `TSC_OP_WR_TUNING: begin
               tuning_d = tsc_tuning_t'(cmd_in.data);
               tuning_d.spare = 1'b0;
            end
            `TSC_OP_WR_CHAN_EN: chan_en_d = cmd_in.data;
            `TSC_OP_BUS_ALERT: bus_alert_d = 1'b1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         setup_q <= tsc_setup_t'(`TSC_SETUP_RESET);
         tuning_q <= tsc_tuning_t'(`TSC_TUNING_RESET);
         chan_en_q <= `TSC_CHAN_EN_RESET;
         bus_alert_q <= 1'b0;
      end else begin
         setup_q <= setup_d;
         tuning_q <= tuning_d;
         chan_en_q <= chan_en_d;
         bus_alert_q <= bus_alert_d;
      end
   end

   // Clock routing, channel power and cascade clock out
   always_comb begin
      route_d.osc_enable = 1'b1;
      route_d.clk_out_enable = tuning_q.clock_output_switch;
      route_d.clk_in_enable = tuning_q.clock_input_switch;
      unique case (setup_q.operating_mode_select)
         TSC_OPM_PRIMARY: route_d.clk_out_enable = 1'b1;
         TSC_OPM_SECONDARY: route_d.clk_in_enable = 1'b1;
         TSC_OPM_ALONE, TSC_OPM_UNUSED: ;
      endcase
      if (route_d.clk_in_enable) begin
         route_d.osc_enable = 1'b0;
      end
      pwr_d = ~chan_en_q & {8{setup_q.masked_channel_power}};
      casc_d = route_q.clk_out_enable ? ~casc_q : 1'b0;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         route_q <= 3'b100;
         pwr_q <= 8'h00;
         casc_q <= 1'b0;
      end else begin
         route_q <= route_d;
         pwr_q <= pwr_d;
         casc_q <= casc_d;
      end
   end

   // Link side: divided cascade clock becomes a slow toggle
   tsc_sync #(.WIDTH(1)) u_en_sync (
      .clk_in(cascade_clk_in),
      .resetn_in(resetn_in),
      .d_in(route_q.clk_in_enable),
      .q_out(link_en)
   );

   always_comb begin
      link_cnt_d = link_cnt_q;
      link_tgl_d = link_tgl_q;
      if (link_en) begin
         if (link_cnt_q == 8'(LINK_DIV - 1)) begin
            link_cnt_d = 8'h00;
            link_tgl_d = ~link_tgl_q;
         end else begin
            link_cnt_d = link_cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge cascade_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link_cnt_q <= 8'h00;
         link_tgl_q <= 1'b0;
      end else begin
         link_cnt_q <= link_cnt_d;
         link_tgl_q <= link_tgl_d;
      end
   end

   tsc_sync #(.WIDTH(1)) u_tick_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .d_in(link_tgl_q),
      .q_out(tgl_s)
   );

   // Sample tick from the selected clock source
   assign link_edge = tgl_s ^ tgl_prev_q;
   assign int_tick = (div_q == 8'h00);
   assign tick = route_q.clk_in_enable ? link_edge : int_tick;
   always_comb begin
      div_d = (div_q == 8'(SAMPLE_DIV - 1)) ? 8'h00 : div_q + 8'h01;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q <= 8'h00;
         tgl_prev_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tgl_prev_q <= tgl_s;
      end
   end

   // Touch state update and alert
   always_comb begin
      logic [7:0] kept;
      logic [3:0] cnt;
      logic set_ev;
      logic clr_ev;
      kept = state_q;
      cnt = 4'h0;
      set_ev = 1'b0;
      clr_ev = 1'b0;
      state_d = state_q;
      if (tick) begin
         if (!setup_q.switch_behaviour_select) begin
            kept = state_q & active;
         end
         state_d = kept;
         cnt = tsc_count(kept);
         for (int i = 0; i < 8; i++) begin
            // Lowest channel wins among simultaneous presses
            if (active[i] && !kept[i] && (cnt < key_limit)) begin
               state_d[i] = 1'b1;
               cnt = cnt + 4'h1;
            end
         end
      end
      // Read drops released bits; presses of this cycle survive
      if (state_read_in && setup_q.switch_behaviour_select) begin
         state_d = state_d & (active | ~state_q);
      end
      set_ev = |(state_d & ~state_q);
      clr_ev = |(state_q & ~state_d);
      if (setup_q.key_press_select == TSC_KEY_TWO) begin
         fire = set_ev && (tsc_count(state_d) >= 4'h2);
      end else if (setup_q.alert_edge_select) begin
         fire = set_ev;
      end else begin
         fire = set_ev || clr_ev;
      end
      // New event beats a clear in the same cycle
      alert_d = fire || (alert_q && !(state_read_in || clear_cmd));
      if (soft_rst) begin
         state_d = `TSC_STATE_RESET;
         alert_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= `TSC_STATE_RESET;
         alert_q <= 1'b0;
      end else begin
         state_q <= state_d;
         alert_q <= alert_d;
      end
   end

   // Read answers one cycle after the request
   always_comb begin
      rd_valid_d = state_read_in;
      rd_data_d = state_q;
      if (cmd_in.valid && !state_read_in) begin
         case (cmd_in.code)
            `TSC_OP_RD_SETUP: begin
               rd_valid_d = 1'b1;
               rd_data_d = setup_q;
            end
            `TSC_OP_RD_TUNING: begin
               rd_valid_d = 1'b1;
               rd_data_d = tuning_q;
            end
            `TSC_OP_RD_CHAN_EN: begin
               rd_valid_d = 1'b1;
               rd_data_d = chan_en_q;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 8'h00;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
      end
   end

   // Outputs
   assign rd_data_out = rd_data_q;
   assign rd_valid_out = rd_valid_q;
   assign alert_n_out = ~alert_q;
   assign bus_alert_mode_out = bus_alert_q;
   assign cascade_clk_out = casc_q;
   assign route_out = route_q;
   assign channel_power_down_out = pwr_q;
   assign regulator_off_out = setup_q.regulator_off;

   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   sequence s_wr_setup;
      cmd_in.valid && (cmd_in.code == `TSC_OP_WR_SETUP);
   endsequence
   sequence s_rd_setup;
      cmd_in.valid && (cmd_in.code == `TSC_OP_RD_SETUP) && !state_read_in;
   endsequence
   sequence s_quiet;
      !cmd_in.valid [*2];
   endsequence

   AST_PRIMARY_CODE: assert property (
      (s_wr_setup and (cmd_in.data[7:6] == 2'h2)) ##1 s_quiet
      |-> route_q.clk_out_enable && route_q.osc_enable)
      else $error("primary code did not drive clock out");
   AST_SOFT_RESET: assert property (
      soft_rst |=> (setup_q == 8'h00) && (state_q == 8'h00)
      && (chan_en_q == 8'hFF) && !bus_alert_q && !alert_q)
      else $error("soft reset left a register set");
   AST_ALONE_ROUTE: assert property (
      (setup_q.operating_mode_select == TSC_OPM_ALONE)
      && !tuning_q.clock_output_switch && !tuning_q.clock_input_switch
      |=> route_q == 3'b100)
      else $error("stand-alone routing wrong");
   AST_SECONDARY_ROUTE: assert property (
      (setup_q.operating_mode_select == TSC_OPM_SECONDARY)
      |=> route_q.clk_in_enable && !route_q.osc_enable
      && (route_q.clk_out_enable == $past(tuning_q.clock_output_switch)))
      else $error("secondary routing wrong");
   AST_DIRECT_RELEASE: assert property (
      tick && !setup_q.switch_behaviour_select && !soft_rst
      |=> (state_q & ~$past(active)) == 8'h00)
      else $error("released channel still set in direct mode");
   AST_LATCH_HOLD: assert property (
      setup_q.switch_behaviour_select && !state_read_in && !soft_rst
      |=> ($past(state_q) & ~state_q) == 8'h00)
      else $error("latched bit lost without a read");
   AST_ONE_KEY: assert property (
      (key_limit == 4'h1) && (state_q != 8'h00) && !soft_rst
      |=> ((state_q & ~$past(state_q)) == 8'h00)
      || (tsc_count(state_q) == 4'h1))
      else $error("second key accepted in 1-key mode");
   AST_ONE_KEY_ALERT: assert property (
      (setup_q.key_press_select == TSC_KEY_ONE)
      && ((state_d & ~state_q) != 8'h00) && !soft_rst |=> alert_q)
      else $error("1-key activation raised no alert");
   AST_TWO_KEY: assert property (
      (key_limit == 4'h2) && (tsc_count(state_q) >= 4'h2) && !soft_rst
      |=> ((state_q & ~$past(state_q)) == 8'h00)
      || (tsc_count(state_q) <= 4'h2))
      else $error("third key accepted in 2-key mode");
   AST_TWO_KEY_ALERT: assert property (
      $rose(alert_q) && ($past(setup_q.key_press_select) == TSC_KEY_TWO)
      |-> tsc_count(state_q) >= 4'h2)
      else $error("2-key alert before two bits set");
   AST_PRESS_ONLY: assert property (
      $rose(alert_q) && $past(setup_q.alert_edge_select)
      |-> (state_q & ~$past(state_q)) != 8'h00)
      else $error("release raised alert in press-only mode");
   AST_ALERT_CLEAR: assert property (
      (state_read_in || clear_cmd) && !fire |=> !alert_q && alert_n_out)
      else $error("alert not dropped by read or clear");
   AST_SETUP_READ: assert property (
      s_rd_setup |=> rd_valid_out && (rd_data_out == $past(setup_q)))
      else $error("setup read-back wrong");

endmodule

`default_nettype wire

// file: tsc_host_model.sv
// Controller model: issues command bytes and state reads to the core.
// Assumes the bench clocks it with clk_in; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"
module tsc_host_model
   import tsc_pkg::*;
(
   input wire logic clk_in,
   input wire logic [7:0] rd_data_in,
   input wire logic rd_valid_in,
   output tsc_cmd_t cmd_out,
   output logic state_read_out
);
   // Idle bus at time zero
   initial begin
      cmd_out = '0;
      state_read_out = 1'b0;
   end

   // Bounded wait for the one-cycle answer pulse
   task automatic get_answer(output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'hXX;
      // The pulse already stands when the request task returns
      for (int n = 0; n < 4 && !ok; n++) begin
         if (rd_valid_in === 1'b1) begin
            ok = 1'b1;
            d = rd_data_in;
         end else begin
            @(negedge clk_in);
         end
      end
   endtask

   // One command byte as a one-cycle pulse
   task automatic send(input logic [7:0] code, input logic [7:0] data);
      logic [7:0] v;
      v = data;
      // Unused mode codes are never written
      if (code == `TSC_OP_WR_SETUP) begin
         if (v[7:6] == 2'h3) v[7:6] = 2'h0;
         if (v[4:3] == 2'h3) v[4:3] = 2'h0;
      end
      @(negedge clk_in);
      cmd_out = {1'b1, code, v};
      @(negedge clk_in);
      cmd_out = '0;
   endtask

   // Register read; the spare tuning bit is ignored
   task automatic read_reg(input logic [7:0] code, output logic [7:0] d,
                           output bit ok);
      send(code, 8'h00);
      get_answer(d, ok);
      // Spare tuning bit may read either way
      if (code == `TSC_OP_RD_TUNING) begin
         d[`TSC_TUNING_SPARE_BIT] = 1'b0;
      end
   endtask

   // Touch state read strobe
   task automatic read_state(output logic [7:0] d, output bit ok);
      @(negedge clk_in);
      state_read_out = 1'b1;
      @(negedge clk_in);
      state_read_out = 1'b0;
      get_answer(d, ok);
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the touch state and setup core.
// Assumes the controller model in tsc_host_model.sv.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"
module tb_top
   import tsc_pkg::*;
;
   logic clk_in, resetn_in, cascade_clk_in, state_read, rd_valid;
   logic alert_n, bus_alert, clk_out, reg_off, a;
   logic [7:0] sense_in, rd_data, pwr_dn, d;
   logic [7:0] vals [8];
   tsc_cmd_t cmd;
   tsc_route_t route;
   int failures, checks_done;
   bit ok;

   tsc_core #(.SAMPLE_DIV(2), .LINK_DIV(8)) tsc_core_i (
      .clk_in(clk_in), .resetn_in(resetn_in),
      .cascade_clk_in(cascade_clk_in), .sense_in(sense_in),
      .cmd_in(cmd), .state_read_in(state_read), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .alert_n_out(alert_n),
      .bus_alert_mode_out(bus_alert), .cascade_clk_out(clk_out),
      .route_out(route), .channel_power_down_out(pwr_dn),
      .regulator_off_out(reg_off));

   tsc_host_model tsc_host_model_i (
      .clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
      .cmd_out(cmd), .state_read_out(state_read));

   // Main clock 50 MHz, link clock 6 ns with its own phase
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      cascade_clk_in = 1'b0;
      #1.7;
      forever #3 cascade_clk_in = ~cascade_clk_in;
   end

   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // Bounded wait for the alert line to reach a level
   task automatic wait_alert(input logic lvl);
      for (int n = 0; n < 200 && alert_n !== lvl; n++) @(negedge clk_in);
      if (alert_n !== lvl) begin
         failures++;
         $display("[ERR] alert_n expected %b seen %b", lvl, alert_n);
         conclude();
      end
   endtask

   task automatic rd_chk(input string name, input logic [7:0] code,
                         input logic [7:0] exp);
      tsc_host_model_i.read_reg(code, d, ok);
      chk(name, exp, d);
   endtask

   task automatic st_chk(input logic [7:0] exp);
      tsc_host_model_i.read_state(d, ok);
      chk("touch_state", exp, d);
   endtask

   task automatic setup(input logic [7:0] v);
      tsc_host_model_i.send(`TSC_OP_WR_SETUP, v);
      idle(2);
   endtask

   task automatic alert_chk(input logic exp);
      chk("alert_n", {7'h00, exp}, {7'h00, alert_n});
   endtask

   initial begin
      failures = 0;
      checks_done = 0;
      resetn_in = 1'b0;
      sense_in = 8'h00;
      vals = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h10, 8'h04, 8'h02, 8'h01};
      repeat (5) @(posedge clk_in);
      @(negedge clk_in);
      resetn_in = 1'b1;
      // Defaults after reset
      chk("route", 8'h04, {5'h00, route});
      chk("clk_out", 8'h00, {7'h00, clk_out});
      rd_chk("setup", `TSC_OP_RD_SETUP, 8'h00);
      rd_chk("tuning", `TSC_OP_RD_TUNING, 8'h0C);
      rd_chk("chan_en", `TSC_OP_RD_CHAN_EN, 8'hFF);
      // Every field and legal mode code written and read back
      for (int i = 0; i < 8; i++) begin
         setup(vals[i]);
         rd_chk("setup", `TSC_OP_RD_SETUP, vals[i]);
         chk("reg_off", {7'h00, vals[i][2]}, {7'h00, reg_off});
      end
      // Primary drives the cascade clock
      setup(8'h80);
      chk("route", 8'h06, {5'h00, route});
      a = clk_out;
      idle(1);
      chk("clk_out toggle", 8'h01, {7'h00, a ^ clk_out});
      // Secondary runs from the link clock
      setup(8'h40);
      chk("route", 8'h01, {5'h00, route});
      chk("clk_out", 8'h00, {7'h00, clk_out});
      sense_in = 8'h80;
      wait_alert(1'b0);
      st_chk(8'h80);
      sense_in = 8'h00;
      wait_alert(1'b0);
      st_chk(8'h00);
      setup(8'h00);
      chk("route", 8'h04, {5'h00, route});
      // Direct mode clears on release without a read
      sense_in = 8'h04;
      wait_alert(1'b0);
      sense_in = 8'h00;
      idle(20);
      st_chk(8'h00);
      alert_chk(1'b1);
      // Latching holds a released key until read
      setup(8'h20);
      sense_in = 8'h02;
      wait_alert(1'b0);
      sense_in = 8'h00;
      idle(20);
      st_chk(8'h02);
      st_chk(8'h00);
      // One key: later presses blocked, early alert tolerated
      setup(8'h10);
      sense_in = 8'h08;
      wait_alert(1'b0);
      sense_in = 8'h28;
      idle(20);
      st_chk(8'h08);
      sense_in = 8'h00;
      idle(20);
      st_chk(8'h00);
      // Two key: alert only once two bits are set
      setup(8'h08);
      sense_in = 8'h01;
      idle(20);
      alert_chk(1'b1);
      sense_in = 8'h11;
      wait_alert(1'b0);
      sense_in = 8'h51;
      idle(20);
      st_chk(8'h11);
      sense_in = 8'h00;
      idle(20);
      st_chk(8'h00);
      // Presses only: a release raises no alert
      setup(8'h02);
      sense_in = 8'h40;
      wait_alert(1'b0);
      st_chk(8'h40);
      sense_in = 8'h00;
      idle(20);
      alert_chk(1'b1);
      // Clear-alert command drops the line without a read
      setup(8'h00);
      sense_in = 8'h20;
      wait_alert(1'b0);
      tsc_host_model_i.send(`TSC_OP_CLEAR_ALERT, 8'h00);
      idle(1);
      alert_chk(1'b1);
      sense_in = 8'h00;
      idle(20);
      st_chk(8'h00);
      // Disabled channels power down only in low-power mode
      tsc_host_model_i.send(`TSC_OP_WR_CHAN_EN, 8'h0F);
      setup(8'h01);
      chk("power_down", 8'hF0, pwr_dn);
      setup(8'h00);
      chk("power_down", 8'h00, pwr_dn);
      // Clock switches of the tuning byte, spare bit ignored
      tsc_host_model_i.send(`TSC_OP_WR_TUNING, 8'hFF);
      idle(2);
      chk("route", 8'h03, {5'h00, route});
      rd_chk("tuning", `TSC_OP_RD_TUNING, 8'hDF);
      // Soft reset restores defaults and ends bus alert mode
      tsc_host_model_i.send(`TSC_OP_BUS_ALERT, 8'h00);
      idle(1);
      chk("bus_alert", 8'h01, {7'h00, bus_alert});
      setup(8'h24);
      tsc_host_model_i.send(`TSC_OP_SOFT_RESET, 8'h00);
      idle(2);
      chk("bus_alert", 8'h00, {7'h00, bus_alert});
      chk("reg_off", 8'h00, {7'h00, reg_off});
      chk("route", 8'h04, {5'h00, route});
      rd_chk("setup", `TSC_OP_RD_SETUP, 8'h00);
      rd_chk("chan_en", `TSC_OP_RD_CHAN_EN, 8'hFF);
      rd_chk("tuning", `TSC_OP_RD_TUNING, 8'h0C);
      conclude();
   end
endmodule
`default_nettype wire
